//--- hw/pwm_out_pkg.sv
package pwm_out_pkg;
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CODE_W = 12;
    localparam int CNT_W = 32;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] PERIOD_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] HIGH_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] MEAS_CNT_OFS = 8'h10;
    // Control field positions
    localparam int CTRL_WIDE_BIT = 0;
    localparam int CTRL_PUSH_BIT = 1;
    localparam int CTRL_TEST_EN_BIT = 2;
    // Status field positions
    localparam int STAT_CODE_LSB = 0;
    localparam int STAT_PEND_BIT = 12;
    localparam int STAT_COIL_BIT = 13;
    localparam int STAT_NEG_BIT = 14;
    localparam int STAT_REQ_BIT = 15;
    // Preset settings after power-up
    localparam logic CTRL_WIDE_RST = 1'b0;
    localparam logic CTRL_PUSH_RST = 1'b1;
    localparam logic CTRL_TEST_EN_RST = 1'b1;
    // Zero field code: half scale
    localparam logic [CODE_W-1:0] CODE_ZERO = 12'h800;
    localparam logic [CODE_W-1:0] CODE_FULL = 12'hfff;
    // Repetition rate preset and clock rate
    localparam int CLK_HZ = 250_000_000;
    localparam int RATE_HZ_RST = 1000;
    localparam int PERIOD_CYC_RST = CLK_HZ / RATE_HZ_RST;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Self-test coil states
    typedef enum logic [0:0]
    {
        ST_IDLE = 1'b0,
        ST_COIL = 1'b1
    } test_state_e;
endpackage : pwm_out_pkg

//--- hw/pwm_core_if.sv
`timescale 1ns/1ps
// Link between register side and period generator
interface pwm_core_if;
    import pwm_out_pkg::*;
    logic [CNT_W-1:0] period;      // Period length in cycles
    logic [CODE_W-1:0] code;       // Code to apply next period
    logic take;                    // Pulse: code taken at period start
    logic level;                   // Current output phase, high first
    logic [CNT_W-1:0] high_cycles; // High time of current period
    // Generator side
    modport core
    (
        input period,
        input code,
        output take,
        output level,
        output high_cycles
    );
    // Control side
    modport ctrl
    (
        output period,
        output code,
        input take,
        input level,
        input high_cycles
    );
endinterface : pwm_core_if

//--- hw/pwm_period_gen.sv
`timescale 1ns/1ps
// Free-running period counter with high-first compare
module pwm_period_gen
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link to control side
    pwm_core_if.core pwm
);
    import pwm_out_pkg::*;

    localparam int PROD_W = CODE_W + CNT_W;

    logic [CNT_W-1:0] cnt_reg;     // Position inside period
    logic [CNT_W-1:0] high_reg;    // High time of running period
    logic first_reg;               // No period has started yet
    logic wrap;                    // Last cycle of a period
    logic [PROD_W-1:0] prod;       // Code times period
    logic [CNT_W-1:0] high_next;   // High time for coming period

    ////////////////////////////////////////////////////////////////
    // scaled high time
    assign prod = {{CNT_W{1'b0}}, pwm.code} *
                  {{CODE_W{1'b0}}, pwm.period};
    assign high_next = (pwm.code == CODE_FULL) ? pwm.period
                                                : prod[PROD_W-1:CODE_W];
    assign wrap = (cnt_reg >= pwm.period - 32'h1);
    // take code only at period boundary
    assign pwm.take = wrap | first_reg;
    assign pwm.level = !first_reg && (cnt_reg < high_reg);
    assign pwm.high_cycles = high_reg;

    ////////////////////////////////////////////////////////////////
    // free-running period counter
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_reg <= 32'h0;
            high_reg <= 32'h0;
            first_reg <= 1'b1;
        end
        else if (pwm.take)
        begin
            cnt_reg <= 32'h0;
            high_reg <= high_next;
            first_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_reg + 32'h1;
        end
    end
endmodule : pwm_period_gen

//--- hw/field_to_pwm_output.sv
`timescale 1ns/1ps
// Function
// - Half scale code means zero field
// - New result applies from next period
// - High ratio spans zero to full
// - Each period starts high, then low
// - Two range settings, narrow and wide
// - Repetition rate fixed at build time
// - Open drain or push-pull drive
// - Coil on while request held low
// - Coil polarity flips every request
// - Preset settings active from reset
module field_to_pwm_output
#(
    // Repetition period in clock cycles
    parameter int PERIOD_CYC = pwm_out_pkg::PERIOD_CYC_RST,
    // High-voltage variant: open drain only
    parameter bit HIGH_VOLTAGE = 1'b0
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [pwm_out_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [pwm_out_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [pwm_out_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [pwm_out_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Measurement from converter
    input wire logic meas_valid,
    input wire logic [pwm_out_pkg::CODE_W-1:0] meas_code,
    output logic range_wide,
    // Self-test request pin
    input wire logic self_test_request_n,
    output logic coil_on,
    output logic coil_negative,
    // Pulse output pin
    output logic pwm_out,
    output logic pwm_oe
);
    import pwm_out_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Declarations
    // Control register fields
    logic wide_reg, push_reg, test_en_reg;
    // Pending and applied field codes
    logic [CODE_W-1:0] pend_code_reg, applied_code_reg;
    logic pend_reg;
    // Measurement counter
    logic [DATA_W-1:0] meas_cnt_reg;
    // Self-test pin synchroniser
    logic req_s1_reg, req_s2_reg, req_s3_reg, req_low_reg;
    // Self-test coil control
    test_state_e test_state_reg, test_state_next;
    logic coil_neg_reg;
    // Output pin registers
    logic pwm_out_reg, pwm_oe_reg;
    // Write channel holding
    logic aw_held_reg, w_held_reg, bvalid_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg;
    // Read channel
    logic rvalid_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [1:0] rresp_reg;
    // Decoded strobes
    logic aw_fire, w_fire, ar_fire, wr_do, wr_ctrl;
    logic wr_hit, rd_hit, push_eff;
    logic [DATA_W-1:0] rd_mux, status_word;
    // Generator link
    pwm_core_if pwm ();

    ////////////////////////////////////////////////////////////////
    // Period generator
    // period is a build-time constant
    assign pwm.period = CNT_W'(PERIOD_CYC);
    assign pwm.code = pend_code_reg;

    pwm_period_gen u_gen
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .pwm(pwm.core)
    );

    ////////////////////////////////////////////////////////////////
    // Measurement capture
    // Latest result waits for the next period boundary
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pend_code_reg <= CODE_ZERO;
            applied_code_reg <= CODE_ZERO;
            pend_reg <= 1'b0;
            meas_cnt_reg <= 32'h0;
        end
        else
        begin
            if (meas_valid)
            begin
                pend_code_reg <= meas_code;
                meas_cnt_reg <= meas_cnt_reg + 32'h1;
            end
            // Arrival wins over a same-cycle take
            if (meas_valid)
                pend_reg <= 1'b1;
            else if (pwm.take)
                pend_reg <= 1'b0;
            // Code in use for the period now starting
            if (pwm.take)
                applied_code_reg <= pend_code_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Self-test pin synchroniser
    // Three stages; level moves only when stages two and three agree
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            req_s1_reg <= 1'b1;
            req_s2_reg <= 1'b1;
            req_s3_reg <= 1'b1;
            req_low_reg <= 1'b0;
        end
        else
        begin
            req_s1_reg <= self_test_request_n;
            req_s2_reg <= req_s1_reg;
            req_s3_reg <= req_s2_reg;
            if (req_s2_reg == req_s3_reg)
                req_low_reg <= !req_s3_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Self-test coil state machine
    // coil held on while request low
    always_comb
    begin
        test_state_next = test_state_reg;
        unique case (test_state_reg)
            ST_IDLE:
            begin
                // Ignored unless the input is enabled
                if (req_low_reg && test_en_reg)
                    test_state_next = ST_COIL;
            end
            ST_COIL:
            begin
                // Release on the pin seen high again
                if (!req_low_reg)
                    test_state_next = ST_IDLE;
            end
        endcase
    end

    // State and polarity registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            test_state_reg <= ST_IDLE;
            coil_neg_reg <= 1'b0;
        end
        else
        begin
            test_state_reg <= test_state_next;
            // flip polarity when a request ends
            if (test_state_reg == ST_COIL && test_state_next == ST_IDLE)
                coil_neg_reg <= !coil_neg_reg;
        end
    end

    // Coil drive; polarity steady during a request
    assign coil_on = (test_state_reg == ST_COIL);
    assign coil_negative = coil_neg_reg;

    ////////////////////////////////////////////////////////////////
    // Output pin drive
    // high-voltage build forces open drain
    assign push_eff = push_reg && !HIGH_VOLTAGE;

    // Registered pin; one cycle behind the generator
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwm_out_reg <= 1'b0;
            pwm_oe_reg <= 1'b0;
        end
        else if (push_eff)
        begin
            // Push-pull: always driven
            pwm_out_reg <= pwm.level;
            pwm_oe_reg <= 1'b1;
        end
        else
        begin
            // Open drain: pull low only in the low phase
            pwm_out_reg <= 1'b0;
            pwm_oe_reg <= !pwm.level;
        end
    end

    assign pwm_out = pwm_out_reg;
    assign pwm_oe = pwm_oe_reg;
    assign range_wide = wide_reg;

    ////////////////////////////////////////////////////////////////
    // AXI4-Lite write path
    // Address and data may come in either order
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire = s_axi_wvalid && s_axi_wready;
    assign wr_do = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_hit = (awaddr_reg[1:0] == 2'b00) &&
                    (awaddr_reg <= MEAS_CNT_OFS);
    assign wr_ctrl = wr_do && (awaddr_reg == CTRL_OFS) && wstrb_reg[0];

    // Hold each half until both are in
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            if (aw_fire)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            else if (wr_do)
                aw_held_reg <= 1'b0;
            if (w_fire)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            else if (wr_do)
                w_held_reg <= 1'b0;
        end
    end

    // Response; read-only words accept and ignore
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end
        else if (wr_do)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_reg <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    ////////////////////////////////////////////////////////////////
    // Control register
    // presets apply with no setup
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wide_reg <= CTRL_WIDE_RST;
            push_reg <= CTRL_PUSH_RST;
            test_en_reg <= CTRL_TEST_EN_RST;
        end
        else if (wr_ctrl)
        begin
            wide_reg <= wdata_reg[CTRL_WIDE_BIT];
            push_reg <= wdata_reg[CTRL_PUSH_BIT];
            test_en_reg <= wdata_reg[CTRL_TEST_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////
    // AXI4-Lite read path
    // Status gathers own state for software
    assign status_word = {16'h0,
                          req_low_reg,
                          coil_neg_reg,
                          coil_on,
                          pend_reg,
                          applied_code_reg};
    assign rd_hit = (s_axi_araddr[1:0] == 2'b00) &&
                    (s_axi_araddr <= MEAS_CNT_OFS);
    // Word select; unmapped reads zero
    assign rd_mux =
        (s_axi_araddr == CTRL_OFS) ?
            {29'h0, test_en_reg, push_eff, wide_reg} :
        (s_axi_araddr == STATUS_OFS) ? status_word :
        (s_axi_araddr == PERIOD_OFS) ? pwm.period :
        (s_axi_araddr == HIGH_OFS) ? pwm.high_cycles :
        (s_axi_araddr == MEAS_CNT_OFS) ? meas_cnt_reg : 32'h0;
    assign s_axi_arready = !rvalid_reg;
    assign ar_fire = s_axi_arvalid && s_axi_arready;

    // One read outstanding; data held until taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
        end
        else if (ar_fire)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

endmodule : field_to_pwm_output

//--- bench/field_to_pwm_output_properties.sv
`timescale 1ns/1ps
// Pin-side checks of the pulse output stage
module field_to_pwm_output_properties
#(
    parameter int PERIOD_CYC = 64
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins
    input wire logic self_test_request_n,
    input wire logic coil_on,
    input wire logic coil_negative,
    input wire logic range_wide,
    input wire logic pwm_out,
    input wire logic pwm_oe
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Pulled-up wire: equals the phase in both drive modes
    logic wire_lvl;
    logic wire_q;
    int since;
    assign wire_lvl = pwm_oe ? pwm_out : 1'b1;
    ////////////////////////////////////////////////////////////////////////
    // Cycles since last wire rise, zero until the first one
    always_ff @(posedge aclk)
    begin
        wire_q <= aresetn ? wire_lvl : 1'b1;
        if (!aresetn)
            since <= 0;
        else if (wire_lvl && !wire_q)
            since <= 1;
        else if (since != 0)
            since <= since + 1;
    end
    property p_preset;
        $rose(aresetn) |-> !coil_on && !coil_negative && !range_wide && !pwm_oe;
    endproperty
    a_preset: assert property (p_preset)
        else $error("outputs not at preset after reset");
    property p_drive;
        pwm_out |-> pwm_oe;
    endproperty
    a_drive: assert property (p_drive)
        else $error("pin high while not driven");
    property p_coil_on;
        $rose(coil_on) |-> !$past(self_test_request_n, 2);
    endproperty
    a_coil_on: assert property (p_coil_on)
        else $error("coil on without request");
    property p_coil_off;
        $fell(coil_on) |-> $past(self_test_request_n, 2);
    endproperty
    a_coil_off: assert property (p_coil_off)
        else $error("coil off while request held");
    property p_coil_hold;
        (coil_on && !self_test_request_n)[*2] |=> coil_on;
    endproperty
    a_coil_hold: assert property (p_coil_hold)
        else $error("coil dropped during request");
    property p_flip;
        $fell(coil_on) |-> coil_negative != $past(coil_negative);
    endproperty
    a_flip: assert property (p_flip)
        else $error("polarity not flipped after request");
    property p_pol_stable;
        coil_on |-> $stable(coil_negative);
    endproperty
    a_pol_stable: assert property (p_pol_stable)
        else $error("polarity moved while coil on");
    property p_period;
        wire_lvl && !wire_q |-> since == 0 || since % PERIOD_CYC == 0;
    endproperty
    a_period: assert property (p_period)
        else $error("period start off the fixed grid");
    // Main scenarios
    c_coil_on: cover property ($rose(coil_on));
    c_coil_off: cover property ($fell(coil_on));
    c_rise: cover property (wire_lvl && !wire_q && since != 0);
endmodule : field_to_pwm_output_properties

bind field_to_pwm_output field_to_pwm_output_properties
    #(.PERIOD_CYC(PERIOD_CYC)) u_field_to_pwm_output_properties
    (.aclk, .aresetn, .self_test_request_n, .coil_on, .coil_negative,
     .range_wide, .pwm_out, .pwm_oe);

//--- bench/pwm_host_monitor.sv
`timescale 1ns/1ps
// Host timer: measures high and period length at each rise
module pwm_host_monitor
(
    // Clock
    input wire logic aclk,
    // Pin as driven
    input wire logic pwm_out,
    input wire logic pwm_oe,
    // Measured values
    output logic wire_lvl,
    output int hi_len,
    output int per_len,
    output int n_rises
);
    logic prev = 1'b1;
    int hi_cnt = 0;
    int per_cnt = 0;
    // Pull-up wins when nobody drives
    assign wire_lvl = pwm_oe ? pwm_out : 1'b1;
    initial n_rises = 0;
    ////////////////////////////////////////////////////////////////////////
    // duty capture
    always @(posedge aclk)
    begin
        prev <= wire_lvl;
        if (wire_lvl && !prev)
        begin
            hi_len <= hi_cnt;
            per_len <= per_cnt;
            n_rises <= n_rises + 1;
            hi_cnt <= 1;
            per_cnt <= 1;
        end
        else
        begin
            hi_cnt <= hi_cnt + int'(wire_lvl);
            per_cnt <= per_cnt + 1;
        end
    end
endmodule : pwm_host_monitor

//--- bench/field_to_pwm_output_tb.sv
`timescale 1ns/1ps
module field_to_pwm_output_tb;
    import pwm_out_pkg::*;
    // Short period keeps the run brief
    localparam int P = 64;
    localparam logic [11:0] CODES [5] = '{12'h000, 12'h041, 12'h7ff,
                                          12'h801, 12'hfff};
    logic aclk, aresetn, meas_valid, range_wide, self_test_request_n;
    logic coil_on, coil_negative, pwm_out, pwm_oe, wire_lvl;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [CODE_W-1:0] meas_code;
    logic [31:0] rd;
    int hi_len, per_len, n_rises, k, c, d;
    int fail_count = 0;
    int n_compared = 0;
    field_to_pwm_output #(.PERIOD_CYC(P)) u_field_to_pwm_output
    (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
     .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
     .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
     .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
     .s_axi_rready, .meas_valid, .meas_code, .range_wide,
     .self_test_request_n, .coil_on, .coil_negative, .pwm_out, .pwm_oe);
    pwm_host_monitor u_pwm_host_monitor
    (.aclk, .pwm_out, .pwm_oe, .wire_lvl, .hi_len, .per_len, .n_rises);
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t %s: got %h want %h", $time, s, got, exp);
        end
    endtask : chk
    // Both halves offered together, each dropped once taken
    task axi_write(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        chk(32'(rs), 32'(RESP_OKAY), "write resp");
        @(posedge aclk);
    endtask : axi_write
    task axi_read(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                rd = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        @(posedge aclk);
    endtask : axi_read
    task meas(input logic [11:0] v);
        meas_code <= v;
        meas_valid <= 1'b1;
        @(posedge aclk);
        meas_valid <= 1'b0;
    endtask : meas
    task rise_wait;
        k = n_rises;
        while (n_rises == k)
            @(posedge aclk);
    endtask : rise_wait
    // Any P-cycle window holds one full period
    task win_high;
        c = 0;
        d = 0;
        repeat (P)
        begin
            @(posedge aclk);
            c += int'(wire_lvl);
            d += int'(pwm_out);
        end
    endtask : win_high
    task coil_wait(input logic e);
        k = 0;
        while (coil_on !== e && k < 20)
        begin
            @(posedge aclk);
            k++;
        end
        chk(32'(coil_on), 32'(e), "coil state");
    endtask : coil_wait
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////
    // Hang guard, far beyond the expected run of under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report;
    end
    initial
    begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, meas_code} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, meas_valid, aresetn} = '0;
        s_axi_wstrb = 4'hf;
        self_test_request_n = 1'b1;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(32'(range_wide), 32'h0, "range preset");
        axi_read(CTRL_OFS);
        chk(rd, 32'h6, "ctrl preset");
        axi_read(PERIOD_OFS);
        chk(rd, P, "period");
        axi_read(HIGH_OFS);
        chk(rd, P / 2, "high time");
        axi_read(STATUS_OFS);
        chk(rd, 32'(CODE_ZERO), "status preset");
        axi_read(8'h40);
        chk({rd[29:0], rs}, 32'(RESP_SLVERR), "unmapped read");
        $display("test presets done");
        rise_wait;
        rise_wait;
        chk(hi_len, P / 2, "zero field duty");
        chk(per_len, P, "period length");
        // Code lands mid-period: current period must finish unchanged
        repeat (5) @(posedge aclk);
        meas(12'hc00);
        rise_wait;
        chk(hi_len, P / 2, "running period kept");
        rise_wait;
        chk(hi_len, P * 3 / 4, "next period updated");
        $display("test update done");
        for (int i = 0; i < 5; i++)
        begin
            meas(CODES[i]);
            repeat (2 * P) @(posedge aclk);
            win_high;
            k = CODES[i] == CODE_FULL ? P : int'(CODES[i]) * P / 4096;
            chk(c, k, "duty sweep");
        end
        meas(CODE_ZERO);
        axi_read(MEAS_CNT_OFS);
        chk(rd, 7, "meas count");
        $display("test sweep done");
        // Wide range with open drain drive
        axi_write(CTRL_OFS, 32'h5);
        chk(32'(range_wide), 32'h1, "wide range");
        repeat (2 * P) @(posedge aclk);
        win_high;
        chk(c, P / 2, "open drain duty");
        chk(d, 0, "open drain never high");
        // Request while self-test disabled is ignored
        axi_write(CTRL_OFS, 32'h2);
        chk(32'(range_wide), 32'h0, "narrow range");
        self_test_request_n <= 1'b0;
        repeat (20) @(posedge aclk);
        chk(32'(coil_on), 32'h0, "disabled request");
        self_test_request_n <= 1'b1;
        repeat (10) @(posedge aclk);
        axi_write(CTRL_OFS, 32'h6);
        $display("test drive done");
        for (int i = 0; i < 2; i++)
        begin
            self_test_request_n <= 1'b0;
            coil_wait(1'b1);
            chk(32'(coil_negative), 32'(i % 2), "polarity");
            repeat (30) @(posedge aclk);
            chk(32'(coil_on), 32'h1, "coil held");
            axi_read(STATUS_OFS);
            chk(rd, {17'h1, 1'(i), 2'b10, CODE_ZERO}, "status");
            self_test_request_n <= 1'b1;
            coil_wait(1'b0);
            chk(32'(coil_negative), 32'((i + 1) % 2), "flip");
        end
        $display("test self-test done");
        final_report;
    end
endmodule : field_to_pwm_output_tb
